// *** sec_ctrl_defs.svh ***
// Function
// - Three register addresses one to three decoded
// - Offset register data treated as two's complement
// - Word takes effect on sixteenth falling edge
// - Word: control, direction, 5-bit address, data
// - Top control bits decode like primary requests
// - Hardware requests honoured in primary words, in secondary only when controls 11
// - Reset clears direction bit: write mode
// - Read returns register in low eight bits
// - Read leaves register contents unchanged
// - Write mode drives all sixteen output bits 0
// - Read ignores data, still acts on phase
// - Address 0 does nothing, reads as 0
// - Filter clock is master over twice divider
// - Master divider resets to decimal 18
// - Conversion clock is filter over divider
// - Conversion divider resets to decimal 18
// - Signed offset shifts sampling by master periods
// - Sampling offset resets to 0
// - Secondary frame scheduled on primary 11 or hardware 11 in a primary frame
// - Secondary 01/10 shift phase, 00 suppresses
// - Secondary word never schedules another secondary
`ifndef SEC_CTRL_DEFS_SVH
`define SEC_CTRL_DEFS_SVH
`define WORD_BITS        16
`define DATA_BITS        8
`define ADDR_BITS        5
`define ADDR_NOOP        5'h00
`define ADDR_MASTER_DIV  5'h01
`define ADDR_CONV_DIV    5'h02
`define ADDR_PHASE_OFS   5'h03
`define ADDR_LAST        5'h08
`define RST_MASTER_DIV   8'h12
`define RST_CONV_DIV     8'h12
`define RST_PHASE_OFS    8'h00
`define CNT_LAST_BIT     4'hf
`define CNT_ADDR_DONE    4'h7
`define CNT_DATA_START   4'h8
`define DIR_POS_AT_ADDR  4
`define REQ_BOTH         2'h3
`define REQ_NONE         2'h0
`define REQ_EARLIER      2'h2
`define REQ_LATER        2'h1
`endif

// *** sec_ctrl_pkg.sv ***
package sec_ctrl_pkg;
  typedef struct packed {
    logic [1:0] ctl;
    logic       dir;
    logic [4:0] addr;
    logic [7:0] data;
  } sec_word_type;

  typedef struct packed {
    logic earlier;
    logic later;
  } phase_req_type;

  typedef enum logic [1:0] {
    ST_IDLE  = 2'b00,
    ST_SHIFT = 2'b01,
    ST_DONE  = 2'b11
  } link_state_type;
endpackage

// *** secondary_control_word_regs.sv ***
`timescale 1ns/100ps
`include "sec_ctrl_defs.svh"
module secondary_control_word_regs
  import sec_ctrl_pkg::*;
#(
  parameter int unsigned WORD_BITS = `WORD_BITS
) (
  input  wire logic       i_clk,                 // Master clock, 20 MHz
  input  wire logic       i_rst_n,               // Async reset, active low
  input  wire logic       i_shift_clk,           // Serial shift clock pin
  input  wire logic       i_frame_n,             // Frame sync pin, low in word
  input  wire logic       i_serial_in,           // Serial data in pin
  input  wire logic       i_hw_request_hi,       // Hardware request pin, high
  input  wire logic       i_hw_request_lo,       // Hardware request pin, low
  output logic            o_serial_out,          // Serial data out
  output logic            o_secondary_pending,   // Next frame is secondary
  output logic            o_phase_earlier,       // Phase shift earlier pulse
  output logic            o_phase_later,         // Phase shift later pulse
  output logic [7:0]      o_master_div,          // Master clock divider
  output logic [7:0]      o_conv_div,            // Conversion divider
  output logic [7:0]      o_phase_offset,        // Signed sampling offset
  output logic            o_filter_clk,          // Filter clock
  output logic            o_sample_strobe        // One pulse per conversion
);

  // Word layout and bit counter both assume a sixteen bit word
  if (WORD_BITS != `WORD_BITS) begin : g_word_bits_check
    $error("Only a sixteen bit control word is supported");
  end
  if ($bits(sec_word_type) != `WORD_BITS) begin : g_word_type_check
    $error("Control word type must be sixteen bits wide");
  end

  // Pin synchronisers; stage one is read only by stage two
  // Reset to the idle levels so no false shift edge follows reset
  logic [4:0] sync1_r;
  logic [4:0] sync2_r;
  logic       sclk_prev_r;

  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      sync1_r     <= 5'h1f;
      sync2_r     <= 5'h1f;
      sclk_prev_r <= 1'b1;
    end else begin
      sync1_r     <= {i_shift_clk, i_frame_n, i_serial_in, i_hw_request_hi, i_hw_request_lo};
      sync2_r     <= sync1_r;
      sclk_prev_r <= sync2_r[4];
    end
  end

  wire       sclk_s   = sync2_r[4];
  wire       frame_s  = sync2_r[3];
  wire       din_s    = sync2_r[2];
  wire [1:0] hw_req_s = sync2_r[1:0];
  wire       sclk_fall = sclk_prev_r & ~sclk_s;
  wire       sclk_rise = ~sclk_prev_r & sclk_s;

  // Serial link state
  link_state_type state_r;
  link_state_type state_nxt;
  logic [3:0]     cnt_r;
  logic [14:0]    rx_r;
  logic           is_sec_r;
  logic           rd_mode_r;
  logic [7:0]     rd_r;

  wire          bit_take   = (state_r == ST_SHIFT) & sclk_fall;
  wire          word_done  = bit_take & (cnt_r == `CNT_LAST_BIT);
  sec_word_type word_w;
  assign word_w = sec_word_type'({rx_r, din_s});

  // After seven bits the direction bit sits just below the two control bits
  wire [4:0] addr_now = {rx_r[3:0], din_s};
  wire       dir_now  = rx_r[`DIR_POS_AT_ADDR];
  wire       addr_take = bit_take & (cnt_r == `CNT_ADDR_DONE);
  wire       frame_start = (state_r == ST_IDLE) & ~frame_s;

  always_comb begin
    state_nxt = state_r;
    case (state_r)
      ST_IDLE:  if (!frame_s) state_nxt = ST_SHIFT;
      ST_SHIFT: begin
        // Only a frame raised before the first bit aborts; short frame pulses are allowed
        if (frame_s && cnt_r == 4'h0) state_nxt = ST_IDLE;
        else if (word_done) state_nxt = ST_DONE;
      end
      ST_DONE:  if (frame_s) state_nxt = ST_IDLE;
      default:  state_nxt = ST_IDLE;
    endcase
  end

  // Configuration registers
  logic [7:0] master_div_r;
  logic [7:0] conv_div_r;
  logic [7:0] phase_ofs_r;

  // Read mux: unimplemented addresses and the no-op slot read zero
  logic [7:0] rd_mux;
  always_comb begin
    case (addr_now)
      `ADDR_MASTER_DIV: rd_mux = master_div_r;
      `ADDR_CONV_DIV:   rd_mux = conv_div_r;
      `ADDR_PHASE_OFS:  rd_mux = phase_ofs_r;
      default:          rd_mux = 8'h00;
    endcase
  end

  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      state_r <= ST_IDLE;
    end else begin
      state_r <= state_nxt;
    end
  end

  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      cnt_r    <= 4'h0;
      rx_r     <= 15'h0000;
      is_sec_r <= 1'b0;
    end else if (frame_start) begin
      cnt_r    <= 4'h0;
      is_sec_r <= o_secondary_pending;
    end else if (bit_take) begin
      cnt_r <= cnt_r + 4'h1;
      rx_r  <= {rx_r[13:0], din_s};
    end
  end

  // Read data is captured once the address is in, and shifted out on rising edges
  wire in_idle   = (state_r == ST_IDLE);
  wire out_shift = sclk_rise & (state_r == ST_SHIFT);
  wire out_data  = rd_mode_r & (cnt_r >= `CNT_DATA_START);

  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      rd_mode_r <= 1'b0;
    end else if (in_idle) begin
      rd_mode_r <= 1'b0;
    end else if (addr_take) begin
      rd_mode_r <= is_sec_r & dir_now;
    end
  end

  // Snapshot only; the register itself is never touched by a read
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      rd_r <= 8'h00;
    end else if (addr_take) begin
      rd_r <= rd_mux;
    end else if (out_shift && out_data) begin
      rd_r <= {rd_r[6:0], 1'b0};
    end
  end

  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      o_serial_out <= 1'b0;
    end else if (in_idle) begin
      o_serial_out <= 1'b0;
    end else if (out_shift) begin
      o_serial_out <= out_data ? rd_r[7] : 1'b0;
    end
  end

  // Request decode at the end of each word
  wire [1:0] sw_req = is_sec_r ? word_w.ctl : word_w.data[1:0];
  wire       sw_phase = (sw_req == `REQ_EARLIER) | (sw_req == `REQ_LATER);
  wire       hw_phase = (hw_req_s == `REQ_EARLIER) | (hw_req_s == `REQ_LATER);
  wire       hw_valid = is_sec_r ? (word_w.ctl == `REQ_BOTH) : 1'b1;
  logic [1:0] phase_sel;
  always_comb begin
    if (sw_phase)
      phase_sel = sw_req;
    else if (hw_valid && hw_phase)
      phase_sel = hw_req_s;
    else
      phase_sel = `REQ_NONE;
  end
  phase_req_type phase_w;
  assign phase_w = phase_req_type'(phase_sel);
  wire sec_sched = ~is_sec_r & ((sw_req == `REQ_BOTH) | (hw_req_s == `REQ_BOTH));

  // Writes land only at the end of a secondary word in write mode
  wire wr_en = word_done & is_sec_r & ~word_w.dir;
  logic ofs_written_r;

  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      master_div_r  <= `RST_MASTER_DIV;
      conv_div_r    <= `RST_CONV_DIV;
      phase_ofs_r   <= `RST_PHASE_OFS;
      ofs_written_r <= 1'b0;
    end else begin
      ofs_written_r <= 1'b0;
      if (wr_en) begin
        case (word_w.addr)
          `ADDR_MASTER_DIV: master_div_r <= word_w.data;
          `ADDR_CONV_DIV:   conv_div_r   <= word_w.data;
          `ADDR_PHASE_OFS: begin
            phase_ofs_r   <= word_w.data;
            ofs_written_r <= 1'b1;
          end
          default: ;
        endcase
      end
    end
  end

  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      o_phase_earlier <= 1'b0;
      o_phase_later   <= 1'b0;
    end else begin
      o_phase_earlier <= word_done & phase_w.earlier;
      o_phase_later   <= word_done & phase_w.later;
    end
  end

  // Pending holds until the next word end, which fixes the type of the next frame
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      o_secondary_pending <= 1'b0;
    end else if (word_done) begin
      o_secondary_pending <= sec_sched;
    end
  end

  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      o_master_div   <= `RST_MASTER_DIV;
      o_conv_div     <= `RST_CONV_DIV;
      o_phase_offset <= `RST_PHASE_OFS;
    end else begin
      o_master_div   <= master_div_r;
      o_conv_div     <= conv_div_r;
      o_phase_offset <= phase_ofs_r;
    end
  end

  // Timebase. A zero divider would stall the clock, so it counts as one.
  // The signed offset is applied once per write as a slip of the master count:
  // positive holds the count, negative counts double, shifting every later sample.
  logic [7:0]        fdiv_r;
  logic [7:0]        cdiv_r;
  logic signed [8:0] slip_r;
  logic              filter_clock_r;
  logic              strobe_r;

  wire [7:0] a_lim = (master_div_r == 8'h00) ? 8'h01 : master_div_r;
  wire [7:0] b_lim = (conv_div_r == 8'h00) ? 8'h01 : conv_div_r;
  wire       slip_hold = slip_r > 9'sd0;
  wire       slip_skip = slip_r < 9'sd0;
  wire [7:0] fdiv_step = slip_skip ? 8'h02 : 8'h01;
  wire [8:0] fdiv_sum  = {1'b0, fdiv_r} + {1'b0, fdiv_step};
  wire       half_end  = ~slip_hold & (fdiv_sum >= {1'b0, a_lim});
  wire       filter_clock_rise = half_end & ~filter_clock_r;
  wire       conv_end  = filter_clock_rise & (cdiv_r + 8'h01 >= b_lim);

  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      fdiv_r   <= 8'h00;
      cdiv_r   <= 8'h00;
      slip_r   <= 9'sd0;
      filter_clock_r   <= 1'b0;
      strobe_r <= 1'b0;
    end else begin
      if (ofs_written_r)
        slip_r <= $signed({phase_ofs_r[7], phase_ofs_r});
      else if (slip_hold)
        slip_r <= slip_r - 9'sd1;
      else if (slip_skip)
        slip_r <= slip_r + 9'sd1;
      if (half_end) begin
        fdiv_r <= 8'h00;
        filter_clock_r <= ~filter_clock_r;
      end else if (!slip_hold) begin
        fdiv_r <= fdiv_sum[7:0];
      end
      if (conv_end)
        cdiv_r <= 8'h00;
      else if (filter_clock_rise)
        cdiv_r <= cdiv_r + 8'h01;
      strobe_r <= conv_end;
    end
  end

  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      o_filter_clk    <= 1'b0;
      o_sample_strobe <= 1'b0;
    end else begin
      o_filter_clk    <= filter_clock_r;
      o_sample_strobe <= strobe_r;
    end
  end

endmodule

// *** secondary_control_word_regs_asserts.sv ***
`timescale 1ns/100ps
module scw_chk (
  input wire logic       i_clk,
  input wire logic       i_rst_n,
  input wire logic       i_shift_clk,
  input wire logic       o_serial_out,
  input wire logic       o_secondary_pending,
  input wire logic       o_phase_earlier,
  input wire logic       o_phase_later,
  input wire logic [7:0] o_master_div,
  input wire logic [7:0] o_conv_div,
  input wire logic [7:0] o_phase_offset,
  input wire logic       o_filter_clk,
  input wire logic       o_sample_strobe
);
  default clocking cb @(posedge i_clk);
  endclocking
  default disable iff (!i_rst_n);
  // Age saturates so idle time between frames reads as old
  logic [3:0] age_r;
  logic [7:0] fcnt_r;
  logic       fok_r;
  logic [7:0] hold_r;
  logic [7:0] scnt_r;
  logic       sok_r;
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      age_r  <= 4'hf;
      fcnt_r <= 8'h01;
      fok_r  <= 1'b0;
      hold_r <= 8'h00;
      scnt_r <= 8'h00;
      sok_r  <= 1'b0;
    end else begin
      age_r  <= $fell(i_shift_clk) ? 4'h0 : age_r + {3'h0, age_r != 4'hf};
      fcnt_r <= $changed(o_filter_clk) ? 8'h01 : fcnt_r + 8'h01;
      // An offset write slips the count for up to 128 cycles; an equal rewrite is not seen
      hold_r <= $changed(o_phase_offset) ? 8'hff : hold_r - {7'h00, hold_r != 8'h00};
      // First half period after a divider change is mixed, so skip it
      fok_r  <= !$changed(o_master_div) && !$changed(o_phase_offset) && hold_r == 8'h00 &&
                (fok_r || $changed(o_filter_clk));
      scnt_r <= o_sample_strobe ? 8'h01 : scnt_r + {7'h00, $rose(o_filter_clk)};
      sok_r  <= !$changed(o_conv_div) && (sok_r || o_sample_strobe);
    end
  end
  property p_rst; $rose(i_rst_n) |-> o_master_div == 8'h12 && o_conv_div == 8'h12; endproperty
  a_rst: assert property (p_rst) else $error("divider reset");
  property p_ofs; $rose(i_rst_n) |-> o_phase_offset == 8'h00; endproperty
  a_ofs: assert property (p_ofs) else $error("offset reset");
  property p_reg; $changed(o_master_div) || $changed(o_conv_div) |-> age_r <= 4'h9; endproperty
  a_reg: assert property (p_reg) else $error("register late");
  property p_pht; o_phase_earlier || o_phase_later |-> age_r <= 4'h9; endproperty
  a_pht: assert property (p_pht) else $error("phase pulse late");
  property p_exc; !(o_phase_earlier && o_phase_later); endproperty
  a_exc: assert property (p_exc) else $error("both phase pulses");
  property p_lpl; o_phase_later |=> !o_phase_later; endproperty
  a_lpl: assert property (p_lpl) else $error("long phase pulse");
  property p_fck;
    $changed(o_filter_clk) && fok_r && age_r > 4'h9 |-> fcnt_r == o_master_div;
  endproperty
  a_fck: assert property (p_fck) else $error("filter clock period");
  property p_sdo; $rose(o_serial_out) |-> age_r <= 4'hc; endproperty
  a_sdo: assert property (p_sdo) else $error("serial out outside frame");
  property p_stb;
    o_sample_strobe && sok_r && !$changed(o_conv_div) |-> scnt_r == o_conv_div;
  endproperty
  a_stb: assert property (p_stb) else $error("conversion strobe period");
  property p_sfc; o_sample_strobe |-> $rose(o_filter_clk); endproperty
  a_sfc: assert property (p_sfc) else $error("strobe off filter clock edge");
endmodule
bind secondary_control_word_regs scw_chk chk_i (
  .i_clk(i_clk), .i_rst_n(i_rst_n), .i_shift_clk(i_shift_clk),
  .o_serial_out(o_serial_out), .o_secondary_pending(o_secondary_pending),
  .o_phase_earlier(o_phase_earlier), .o_phase_later(o_phase_later),
  .o_master_div(o_master_div), .o_conv_div(o_conv_div),
  .o_phase_offset(o_phase_offset), .o_filter_clk(o_filter_clk),
  .o_sample_strobe(o_sample_strobe)
);

// *** host_port_model.sv ***
`timescale 1ns/100ps
module host_port_model (
  input  wire logic i_clk,        // Master clock
  input  wire logic i_serial_out, // Device serial out
  output logic      o_shift_clk,  // Shift clock, idle high
  output logic      o_frame_n,    // Frame sync, low in word
  output logic      o_serial_in   // Serial data to device
);
  initial begin
    o_shift_clk = 1'b1;
    o_frame_n   = 1'b1;
    o_serial_in = 1'b0;
  end
  // Six master cycles a level, above the three the synchronisers need
  task automatic xfer(input logic [15:0] w, output logic [15:0] r);
    r = 16'h0000;
    o_frame_n <= 1'b0;
    repeat (6) @(posedge i_clk);
    for (int i = 15; i >= 0; i--) begin
      o_serial_in <= w[i];
      repeat (6) @(posedge i_clk);
      r = {r[14:0], i_serial_out};
      o_shift_clk <= 1'b0;
      repeat (6) @(posedge i_clk);
      o_shift_clk <= 1'b1;
    end
    repeat (6) @(posedge i_clk);
    o_frame_n   <= 1'b1;
    o_serial_in <= ~w[0];
    repeat (8) @(posedge i_clk);
  endtask
endmodule

// *** tb_secondary_control_word_regs.sv ***
`timescale 1ns/100ps
module tb_secondary_control_word_regs;
  import sec_ctrl_pkg::*;
  logic        clk = 1'b0;
  logic        rst_n = 1'b0;
  logic [1:0]  hw = 2'h0;
  logic        sck, fs_n, sdi, sdo, pend, pe, pl, filter_clock;
  logic [7:0]  mdiv, cdiv, pofs;
  logic        se = 1'b0;
  logic        sl = 1'b0;
  logic        clr = 1'b0;
  logic [15:0] rd;
  int          errors = 0;
  int          samples_checked = 0;
  int          cyc = 0;
  always #25 clk = ~clk;
  secondary_control_word_regs dut (
    .i_clk(clk), .i_rst_n(rst_n), .i_shift_clk(sck), .i_frame_n(fs_n),
    .i_serial_in(sdi), .i_hw_request_hi(hw[1]), .i_hw_request_lo(hw[0]),
    .o_serial_out(sdo), .o_secondary_pending(pend), .o_phase_earlier(pe),
    .o_phase_later(pl), .o_master_div(mdiv), .o_conv_div(cdiv),
    .o_phase_offset(pofs), .o_filter_clk(filter_clock), .o_sample_strobe()
  );
  host_port_model host (.i_clk(clk), .i_serial_out(sdo), .o_shift_clk(sck),
    .o_frame_n(fs_n), .o_serial_in(sdi));
  task automatic end_sim();
    $display("errors=%0d samples_checked=%0d", errors, samples_checked);
    if (errors == 0 && samples_checked > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask
  // Phase pulses last one cycle, so latch them for the scenarios
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (pe) se <= 1'b1;
    else if (clr) se <= 1'b0;
    if (pl) sl <= 1'b1;
    else if (clr) sl <= 1'b0;
    if (cyc == 20000) begin
      errors++;
      end_sim();
    end
  end
  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      errors++;
      $display("mismatch at %0t: saw %h want %h", $time, seen, exp);
    end
  endtask
  task automatic sec(input sec_word_type w);
    host.xfer(16'h0003, rd);
    chk(pend, 1'b1);
    clr <= 1'b1;
    @(posedge clk);
    clr <= 1'b0;
    host.xfer(w, rd);
    chk(pend, 1'b0);
  endtask
  task automatic t_reset();
    rst_n <= 1'b0;
    repeat (8) @(posedge clk);
    rst_n <= 1'b1;
    repeat (4) @(posedge clk);
    chk({mdiv, cdiv}, 16'h1212);
    chk(pofs, 8'h00);
    chk(sdo, 1'b0);
    $display("reset done");
  endtask
  task automatic t_regs();
    logic [7:0] wv [5] = '{8'h5a, 8'h03, 8'h07, 8'h80, 8'h5a};
    logic [7:0] ev [5] = '{8'h00, 8'h03, 8'h07, 8'h80, 8'h00};
    for (int i = 0; i < 5; i++) begin
      sec('{2'h0, 1'b0, 5'(i), wv[i]});
      chk(rd, 16'h0000);
      sec('{2'h0, 1'b1, 5'(i), ~wv[i]});
      chk(rd, {8'h00, ev[i]});
    end
    chk(mdiv, 8'h03);
    chk(cdiv, 8'h07);
    chk(pofs, 8'h80);
    $display("registers done");
  endtask
  task automatic t_phase();
    logic [5:0] tab [7] = '{6'h22, 6'h11, 6'h08, 6'h3a, 6'h35, 6'h19, 6'h3c};
    for (int i = 0; i < 7; i++) begin
      hw <= tab[i][3:2];
      sec('{tab[i][5:4], 1'b1, 5'h00, 8'h00});
      chk({se, sl}, tab[i][1:0]);
    end
    hw <= 2'h0;
    $display("phase done");
  endtask
  task automatic t_pend();
    host.xfer(16'h0000, rd);
    chk(pend, 1'b0);
    hw <= 2'h3;
    host.xfer(16'h0000, rd);
    chk(pend, 1'b1);
    hw <= 2'h0;
    host.xfer(16'h0125, rd);
    chk(pend, 1'b0);
    chk(mdiv, 8'h25);
    $display("pending done");
  endtask
  initial begin
    t_reset();
    t_regs();
    t_phase();
    t_pend();
    t_reset();
    end_sim();
  end
endmodule
